// *** design/fsr_pkg.sv ***
// Shared constants, types and carriers of the flash status register bank.
// Assumes a single hclk domain and a 32-bit AHB-Lite slave port.
// Notes on behaviour
// - program completion sets program done flag
// - erase completion sets erase done flag
// - program/erase flags clear on write0, reset, autoclear
// - reset completion or warm release sets reset flag
// - reset flag clears only by write0, autoclear or cold reset
// - end block register is reserved, no function
// - protect state bits open/closed/sealed, reset 0002
// - ECC corrects one bit, detects two
// - ECC code 00 none, 01 fixed, 10 bad
// - eight codes, sector 3 on top bits
// - separate codes for main and spare areas
// - ECC fields update on load and boot load
// - ECC results clear on every new command
// - master bit sets on any completion flag
// - status resets 8080 cold, 8010 after warm release; hot reset keeps the reset flag
// - interrupt pin follows master bit and polarity
package fsr_pkg;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_IRQ_STATUS = 16'hF241;
  localparam logic [15:0] IDX_LOCK_START = 16'hF24C;
  localparam logic [15:0] IDX_LOCK_END = 16'hF24D;
  localparam logic [15:0] IDX_PROTECT = 16'hF24E;
  localparam logic [15:0] IDX_ECC = 16'hFF00;
  localparam logic [15:0] IDX_IRQ_CTRL = 16'hF250;
  localparam logic [15:0] IDX_FLASH_BLOCK = 16'hF251;

  // Interrupt status fields and reset values
  localparam int IRQ_MASTER_BIT = 15;
  localparam int LOAD_BIT = 7;
  localparam int PROG_BIT = 6;
  localparam int ERASE_BIT = 5;
  localparam int RESET_BIT = 4;
  localparam logic [15:0] IRQ_COLD_RST = 16'h8080;
  localparam logic [15:0] IRQ_WARM_RST = 16'h8010;

  // Control register fields: pin polarity and automatic clearing
  localparam int CTRL_POL_BIT = 0;
  localparam int CTRL_AUTO_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h1;

  localparam logic [15:0] LOCK_START_RST = 16'h0000;
  localparam logic [15:0] FLASH_BLOCK_RST = 16'h0000;
  localparam logic [15:0] ECC_RST = 16'h0000;

  // Protection read-back patterns
  localparam logic [2:0] PROT_OPEN_PAT = 3'h4;
  localparam logic [2:0] PROT_CLOSED_PAT = 3'h2;
  localparam logic [2:0] PROT_SEALED_PAT = 3'h1;

  // Command codes seen on completion
  localparam logic [15:0] CMD_PROG_A = 16'h0080;
  localparam logic [15:0] CMD_PROG_B = 16'h001A;
  localparam logic [15:0] CMD_PROG_C = 16'h001B;
  localparam logic [15:0] CMD_ERASE_A = 16'h0094;
  localparam logic [15:0] CMD_ERASE_B = 16'h0095;
  localparam logic [15:0] CMD_ERASE_C = 16'h0030;
  localparam logic [15:0] CMD_RST_A = 16'h00B0;
  localparam logic [15:0] CMD_RST_B = 16'h00F0;
  localparam logic [15:0] CMD_RST_C = 16'h00F3;
  localparam logic [15:0] CMD_LOAD_A = 16'h0000;
  localparam logic [15:0] CMD_LOAD_B = 16'h000E;
  localparam logic [15:0] CMD_LOAD_C = 16'h000C;
  localparam logic [15:0] CMD_LOAD_D = 16'h000A;
  localparam logic [15:0] CMD_LOAD_E = 16'h0013;
  localparam logic [15:0] CMD_MISC_A = 16'h0065;
  localparam logic [15:0] CMD_MISC_B = 16'h0023;
  localparam logic [15:0] CMD_MISC_C = 16'h0071;
  localparam logic [15:0] CMD_MISC_D = 16'h002A;
  localparam logic [15:0] CMD_MISC_E = 16'h0027;
  localparam logic [15:0] CMD_MISC_F = 16'h002C;

  localparam int NUM_SECTORS = 4;
  localparam int SECTOR_FIELD_W = 4;

  typedef enum logic [1:0] {
    FSR_ECC_NONE = 2'h0,
    FSR_ECC_FIXED = 2'h1,
    FSR_ECC_BAD = 2'h2,
    FSR_ECC_RSVD = 2'h3
  } fsr_ecc_code_t;

  typedef enum logic [1:0] {
    FSR_LOCK_OPEN,
    FSR_LOCK_CLOSE,
    FSR_LOCK_SEAL
  } fsr_lock_op_t;

  typedef enum logic [1:0] {
    FSR_BLK_OPEN,
    FSR_BLK_CLOSED,
    FSR_BLK_SEALED
  } fsr_blk_state_t;

  // Operation finished, with the command that started it
  typedef struct packed {
    logic done;
    logic [15:0] cmd;
  } fsr_op_evt_t;

  // ECC result of one loaded sector; errs counts bits found wrong
  typedef struct packed {
    logic valid;
    logic [1:0] sector;
    logic [1:0] main_errs;
    logic [1:0] spare_errs;
  } fsr_ecc_evt_t;

  typedef struct packed {
    logic valid;
    fsr_lock_op_t op;
  } fsr_lock_evt_t;

endpackage

// *** design/fsr_ecc_slot.sv ***
// One selected sector's ECC result: a main and a spare area code.
// Assumes update and clear are single-cycle strobes on hclk.
`timescale 1ns/1ps
module fsr_ecc_slot (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Result capture
  input wire logic clear,
  input wire logic update,
  input wire logic [1:0] main_errs,
  input wire logic [1:0] spare_errs,
  // Main and spare area codes as two separate outputs
  output fsr_pkg::fsr_ecc_code_t main_code,
  output fsr_pkg::fsr_ecc_code_t spare_code
);
  import fsr_pkg::*;

  fsr_ecc_code_t main_reg, main_next;
  fsr_ecc_code_t spare_reg, spare_next;

  // Three or more wrong bits cannot be told apart from two
  function automatic fsr_ecc_code_t encode(input logic [1:0] errs);
    case (errs)
      2'h0: encode = FSR_ECC_NONE;
      2'h1: encode = FSR_ECC_FIXED;
      default: encode = FSR_ECC_BAD;
    endcase
  endfunction

  always_comb begin
    main_next = main_reg;
    spare_next = spare_reg;
    // A result landing with a new command is kept, not lost
    if (update) begin
      main_next = encode(main_errs);
      spare_next = encode(spare_errs);
    end else if (clear) begin
      main_next = FSR_ECC_NONE;
      spare_next = FSR_ECC_NONE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      main_reg <= FSR_ECC_NONE;
      spare_reg <= FSR_ECC_NONE;
    end else begin
      main_reg <= main_next;
      spare_reg <= spare_next;
    end
  end

  assign main_code = main_reg;
  assign spare_code = spare_reg;

endmodule // fsr_ecc_slot

// *** design/fsr_ahb_slv.sv ***
// AHB-Lite slave front end: writes take no wait, reads take one.
// Assumes one master, word transfers only; every answer is OKAY.
`timescale 1ns/1ps
module fsr_ahb_slv (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic [31:0] haddr,
  input wire logic hwrite,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Register file side
  output logic wr_stb,
  output logic [15:0] acc_idx,
  output logic acc_hit,
  input wire logic [31:0] rd_data
);
  import fsr_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_WRITE, S_READ} fsr_bus_st_t;

  fsr_bus_st_t st_reg, st_next;
  logic [15:0] idx_reg, idx_next;
  logic hit_reg, hit_next;
  logic rdy_reg, rdy_next;
  logic [31:0] rdata_reg, rdata_next;
  logic take;

  // Address phase taken only when the bus is ready and NONSEQ/SEQ
  assign take = hsel && htrans[1] && hready;

  always_comb begin
    st_next = S_IDLE;
    idx_next = idx_reg;
    hit_next = hit_reg;
    rdy_next = 1'b1;
    rdata_next = rdata_reg;
    case (st_reg)
      S_READ: begin
        // Read data is sampled here so a write just before is seen
        rdata_next = hit_reg ? rd_data : 32'h0000_0000;
      end
      default: begin
        if (take) begin
          idx_next = haddr[17:2];
          hit_next = (haddr[31:18] == 14'h0000) && (haddr[1:0] == 2'h0);
          st_next = hwrite ? S_WRITE : S_READ;
          rdy_next = hwrite;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= S_IDLE;
      idx_reg <= 16'h0000;
      hit_reg <= 1'b0;
      rdy_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else begin
      st_reg <= st_next;
      idx_reg <= idx_next;
      hit_reg <= hit_next;
      rdy_reg <= rdy_next;
      rdata_reg <= rdata_next;
    end
  end

  assign wr_stb = (st_reg == S_WRITE) && hit_reg;
  assign acc_idx = idx_reg;
  assign acc_hit = hit_reg;
  assign hreadyout = rdy_reg;
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;

endmodule // fsr_ahb_slv

// *** design/fsr_top.sv ***
// Flash status register bank: completion flags, block protection
// and per-sector ECC results behind an AHB-Lite slave.
// Assumes the command engine gives single-cycle event strobes on hclk.
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ps
module fsr_top #(
  parameter int NUM_BLOCKS = 1024,
  parameter int BLK_W = 10
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic [31:0] haddr,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Command engine events
  input wire logic cmd_written,
  input wire fsr_pkg::fsr_op_evt_t op_evt,
  input wire logic boot_load_done,
  input wire fsr_pkg::fsr_ecc_evt_t ecc_evt,
  input wire fsr_pkg::fsr_lock_evt_t lock_evt,
  input wire logic otp_first_locked,
  // Warm reset level and hot reset strobe
  input wire logic warm_rst_active,
  input wire logic hot_rst_pulse,
  // Outputs to the chip
  output logic irq_out,
  output logic [BLK_W-1:0] lock_first_block
);
  import fsr_pkg::*;

  // Bus front end
  logic wr_stb;
  logic [15:0] acc_idx;
  logic acc_hit;
  logic [31:0] rd_data;

  fsr_ahb_slv u_bus (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .htrans(htrans),
    .haddr(haddr),
    .hwrite(hwrite),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .wr_stb(wr_stb),
    .acc_idx(acc_idx),
    .acc_hit(acc_hit),
    .rd_data(rd_data)
  );

  logic wr_irq, wr_ctrl, wr_start, wr_fblk;
  assign wr_irq = wr_stb && (acc_idx == IDX_IRQ_STATUS);
  assign wr_ctrl = wr_stb && (acc_idx == IDX_IRQ_CTRL);
  assign wr_start = wr_stb && (acc_idx == IDX_LOCK_START);
  assign wr_fblk = wr_stb && (acc_idx == IDX_FLASH_BLOCK);

  // Event decode
  logic ev_prog, ev_erase, ev_rst, ev_load, ev_misc;

  always_comb begin
    ev_prog = 1'b0;
    ev_erase = 1'b0;
    ev_rst = 1'b0;
    ev_load = boot_load_done;
    ev_misc = 1'b0;
    if (op_evt.done) begin
      case (op_evt.cmd)
        CMD_PROG_A, CMD_PROG_B, CMD_PROG_C: ev_prog = 1'b1;
        CMD_ERASE_A, CMD_ERASE_B, CMD_ERASE_C: ev_erase = 1'b1;
        CMD_RST_A, CMD_RST_B, CMD_RST_C: ev_rst = 1'b1;
        CMD_LOAD_A, CMD_LOAD_B, CMD_LOAD_C, CMD_LOAD_D,
        CMD_LOAD_E: ev_load = 1'b1;
        CMD_MISC_A, CMD_MISC_B, CMD_MISC_C, CMD_MISC_D,
        CMD_MISC_E, CMD_MISC_F: ev_misc = 1'b1;
        default: ;
      endcase
    end
  end

  // Interrupt status, control and pin
  logic [15:0] irq_reg, irq_next;
  logic [1:0] ctrl_reg, ctrl_next;
  logic pin_reg, pin_next;
  logic warm_seen_reg, warm_seen_next;
  logic warm_release, in_reset, auto_clr;

  // Release is the falling edge of the warm reset level
  assign warm_release = warm_seen_reg && !warm_rst_active;
  assign in_reset = warm_rst_active || hot_rst_pulse;
  assign auto_clr = cmd_written && ctrl_reg[CTRL_AUTO_BIT];

  always_comb begin
    irq_next = irq_reg;
    ctrl_next = ctrl_reg;
    warm_seen_next = warm_rst_active;
    if (wr_ctrl) begin
      ctrl_next = hwdata[1:0];
    end
    // Clears first, so that a set in the same cycle wins; program and erase sets are blocked during a reset
    if (wr_irq) begin
      // Writing one has no effect; only zero clears
      irq_next[IRQ_MASTER_BIT] = irq_reg[IRQ_MASTER_BIT]
                                 & hwdata[IRQ_MASTER_BIT];
      irq_next[LOAD_BIT] = irq_reg[LOAD_BIT] & hwdata[LOAD_BIT];
      irq_next[PROG_BIT] = irq_reg[PROG_BIT] & hwdata[PROG_BIT];
      irq_next[ERASE_BIT] = irq_reg[ERASE_BIT]
                            & hwdata[ERASE_BIT];
      irq_next[RESET_BIT] = irq_reg[RESET_BIT]
                            & hwdata[RESET_BIT];
    end
    if (auto_clr) begin
      irq_next[LOAD_BIT] = 1'b0;
      irq_next[PROG_BIT] = 1'b0;
      irq_next[ERASE_BIT] = 1'b0;
      irq_next[RESET_BIT] = 1'b0;
    end
    // Warm/hot reset: reset flag is kept, load/program/erase flags go to zero, master bit to one
    if (in_reset) begin
      irq_next[LOAD_BIT] = 1'b0;
      irq_next[PROG_BIT] = 1'b0;
      irq_next[ERASE_BIT] = 1'b0;
      irq_next[IRQ_MASTER_BIT] = IRQ_WARM_RST[IRQ_MASTER_BIT];
    end
    if (ev_load) begin
      irq_next[LOAD_BIT] = 1'b1;
    end
    if (ev_prog && !in_reset) begin
      irq_next[PROG_BIT] = 1'b1;
    end
    if (ev_erase && !in_reset) begin
      irq_next[ERASE_BIT] = 1'b1;
    end
    if (ev_rst || warm_release) begin
      irq_next[RESET_BIT] = 1'b1;
    end
    if (ev_load || ev_prog || ev_erase || ev_rst || warm_release
        || ev_misc) begin
      irq_next[IRQ_MASTER_BIT] = 1'b1;
    end
    // Reserved positions never hold a one
    irq_next = irq_next & (IRQ_COLD_RST | IRQ_WARM_RST
               | (16'h0001 << PROG_BIT) | (16'h0001 << ERASE_BIT));
    // Pin is registered from the next master value, no extra lag
    pin_next = ctrl_next[CTRL_POL_BIT] ? irq_next[IRQ_MASTER_BIT]
                                       : !irq_next[IRQ_MASTER_BIT];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_reg <= IRQ_COLD_RST;
      ctrl_reg <= CTRL_RST;
      pin_reg <= IRQ_COLD_RST[IRQ_MASTER_BIT];
      warm_seen_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
      ctrl_reg <= ctrl_next;
      pin_reg <= pin_next;
      warm_seen_reg <= warm_seen_next;
    end
  end

  assign irq_out = pin_reg;

  // Lock start block, selected block and per-block protection
  logic [BLK_W-1:0] start_reg, start_next;
  logic [BLK_W-1:0] fblk_reg, fblk_next;
  fsr_blk_state_t prot_reg [NUM_BLOCKS];
  fsr_blk_state_t prot_next [NUM_BLOCKS];
  fsr_blk_state_t cur_state;
  logic [2:0] prot_pat;

  always_comb begin
    start_next = start_reg;
    fblk_next = fblk_reg;
    prot_next = prot_reg;
    if (wr_start) begin
      start_next = hwdata[BLK_W-1:0];
    end
    if (wr_fblk) begin
      fblk_next = hwdata[BLK_W-1:0];
    end
    // Lock commands act on the block loaded beforehand
    if (lock_evt.valid) begin
      case (lock_evt.op)
        FSR_LOCK_OPEN: begin
          if (prot_reg[start_reg] != FSR_BLK_SEALED) begin
            prot_next[start_reg] = FSR_BLK_OPEN;
          end
        end
        FSR_LOCK_CLOSE: begin
          if (prot_reg[start_reg] != FSR_BLK_SEALED) begin
            prot_next[start_reg] = FSR_BLK_CLOSED;
          end
        end
        FSR_LOCK_SEAL: begin
          // Only a closed block can be sealed; unseal needs cold reset
          if (prot_reg[start_reg] == FSR_BLK_CLOSED) begin
            prot_next[start_reg] = FSR_BLK_SEALED;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_reg <= LOCK_START_RST[BLK_W-1:0];
      fblk_reg <= FLASH_BLOCK_RST[BLK_W-1:0];
      for (int i = 0; i < NUM_BLOCKS; i++) begin
        prot_reg[i] <= FSR_BLK_CLOSED;
      end
    end else begin
      start_reg <= start_next;
      fblk_reg <= fblk_next;
      prot_reg <= prot_next;
    end
  end

  assign lock_first_block = start_reg;
  assign cur_state = prot_reg[fblk_reg];

  always_comb begin
    case (cur_state)
      FSR_BLK_OPEN: prot_pat = PROT_OPEN_PAT;
      FSR_BLK_SEALED: prot_pat = PROT_SEALED_PAT;
      default: prot_pat = PROT_CLOSED_PAT;
    endcase
    // A one-time-programmed first block always reads as closed
    if (otp_first_locked && (fblk_reg == '0)) begin
      prot_pat = PROT_CLOSED_PAT;
    end
  end

  // ECC results, one slot per selected sector
  logic [15:0] ecc_word;

  for (genvar s = 0; s < NUM_SECTORS; s++) begin : g_ecc
    fsr_ecc_code_t mcode, scode;
    fsr_ecc_slot u_slot (
      .hclk(hclk),
      .hresetn(hresetn),
      .clear(cmd_written),
      .update(ecc_evt.valid && (ecc_evt.sector == s)),
      .main_errs(ecc_evt.main_errs),
      .spare_errs(ecc_evt.spare_errs),
      .main_code(mcode),
      .spare_code(scode)
    );
    // Sector 0 sits lowest, main code above spare
    assign ecc_word[SECTOR_FIELD_W*s +: SECTOR_FIELD_W] =
      {mcode, scode};
  end

  // Read-back; unmapped and reserved locations read zero
  always_comb begin
    rd_data = 32'h0000_0000;
    if (acc_hit) begin
      case (acc_idx)
        IDX_IRQ_STATUS: rd_data[15:0] = irq_reg;
        IDX_IRQ_CTRL: rd_data[1:0] = ctrl_reg;
        IDX_LOCK_START: rd_data[BLK_W-1:0] = start_reg;
        IDX_LOCK_END: rd_data = 32'h0000_0000;
        IDX_PROTECT: rd_data[2:0] = prot_pat;
        IDX_FLASH_BLOCK: rd_data[BLK_W-1:0] = fblk_reg;
        IDX_ECC: rd_data[15:0] = ecc_word;
        default: rd_data = 32'h0000_0000;
      endcase
    end
  end

endmodule // fsr_top

// *** dv/fsr_checker.sv ***
// Port assertions of the flash status register bank.
// Assumes one hclk domain and single word transfers from one master.
`timescale 1ns/1ps
module fsr_checker #(
  parameter int NUM_BLOCKS = 1024,
  parameter int BLK_W = 10
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic [31:0] haddr,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  // Events and pins
  input wire logic cmd_written,
  input wire fsr_pkg::fsr_op_evt_t op_evt,
  input wire fsr_pkg::fsr_ecc_evt_t ecc_evt,
  input wire logic irq_out,
  input wire logic [BLK_W-1:0] lock_first_block
);
  import fsr_pkg::*;
  logic ok, rd_ok, lk_wr_reg, lk_wr_next, clean_reg, clean_next;
  logic [15:0] idx;
  assign idx = haddr[17:2];
  assign ok = hsel && htrans[1] && hready && haddr[31:18] == 14'h0
    && haddr[1:0] == 2'h0;
  assign rd_ok = ok && !hwrite;
  // ECC clean: a command came and no result was loaded since
  always_comb begin
    lk_wr_next = ok && hwrite && idx == IDX_LOCK_START;
    clean_next = clean_reg;
    if (cmd_written) clean_next = 1'b1;
    if (ecc_evt.valid) clean_next = 1'b0;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lk_wr_reg <= 1'b0;
      clean_reg <= 1'b1;
    end else begin
      lk_wr_reg <= lk_wr_next;
      clean_reg <= clean_next;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_LOCK_COPY: assert property (lk_wr_reg && hready |=>
    lock_first_block == $past(hwdata[BLK_W-1:0])) else $error("bad copy");
  AST_RD_WAIT: assert property (hsel && htrans[1] && hready && !hwrite
    |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
  AST_PROT: assert property (rd_ok && idx == IDX_PROTECT |-> ##2
    hrdata[31:3] == 29'h0 && $onehot(hrdata[2:0])) else $error("prot");
  AST_END_RSVD: assert property (rd_ok && idx == IDX_LOCK_END |->
    ##2 hrdata == 32'h0) else $error("end block not zero");
  AST_ECC_CODE: assert property (rd_ok && idx == IDX_ECC |-> ##2
    hrdata[31:16] == 16'h0 && (hrdata[15:0] & (hrdata[15:0] >> 1)
    & 32'h5555) == 32'h0) else $error("ecc code 11 seen");
  AST_IRQ_RSVD: assert property (rd_ok && idx == IDX_IRQ_STATUS |->
    ##2 hrdata[31:16] == 16'h0 && hrdata[14:8] == 7'h0
    && hrdata[3:0] == 4'h0) else $error("status reserved set");
  AST_COLD: assert property ($rose(hresetn) |-> irq_out
    && lock_first_block == '0) else $error("cold values wrong");
  AST_ECC_CLEAR: assert property (rd_ok && idx == IDX_ECC && clean_reg
    && !ecc_evt.valid ##1 !ecc_evt.valid |=> hrdata[15:0] == 16'h0)
    else $error("ecc not cleared");
  COV_PROT: cover property (rd_ok && idx == IDX_PROTECT);
  COV_LOCK: cover property (lk_wr_reg);
  COV_DONE: cover property (op_evt.done);
endmodule // fsr_checker

bind fsr_top fsr_checker #(.NUM_BLOCKS(NUM_BLOCKS), .BLK_W(BLK_W)) chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .haddr(haddr), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
  .hreadyout(hreadyout), .hrdata(hrdata), .cmd_written(cmd_written),
  .op_evt(op_evt), .ecc_evt(ecc_evt), .irq_out(irq_out),
  .lock_first_block(lock_first_block));

// *** dv/fsr_host.sv ***
// Host model: one AHB-Lite master doing single word transfers.
// Assumes hready is the slave's hreadyout fed back.
`timescale 1ns/1ps
module fsr_host (
  // Clock
  input wire logic hclk,
  // AHB-Lite
  output logic hsel,
  output logic [1:0] htrans,
  output logic [31:0] haddr,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  initial begin
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // Byte address is four times the register index
  task automatic xfer(input logic wr, input logic [15:0] idx,
    input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {14'h0, idx, 2'h0};
    hwrite <= wr;
    // Released data lines never keep the old word
    hwdata <= ~hwdata;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    haddr <= ~haddr;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
endmodule // fsr_host

// *** dv/test_flash_status_registers.sv ***
// Self-checking bench of the flash status register bank.
// Assumes the host model for bus cycles; events are driven here.
`timescale 1ns/1ps
module test_flash_status_registers;
  import fsr_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, irq_out;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [9:0] lock_first_block;
  logic cmd_written = 1'b0;
  logic boot_load_done = 1'b0;
  logic otp_first_locked = 1'b0;
  logic warm_rst_active = 1'b0;
  logic hot_rst_pulse = 1'b0;
  fsr_op_evt_t op_evt = '0;
  fsr_ecc_evt_t ecc_evt = '0;
  fsr_lock_evt_t lock_evt = '0;
  int n_fail = 0;
  int checked = 0;
  always #2 hclk = ~hclk;
  fsr_host host (.hclk(hclk), .hsel(hsel), .htrans(htrans), .haddr(haddr),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata));
  fsr_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
    .haddr(haddr), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .cmd_written(cmd_written), .op_evt(op_evt), .ecc_evt(ecc_evt),
    .boot_load_done(boot_load_done), .lock_evt(lock_evt),
    .otp_first_locked(otp_first_locked), .warm_rst_active(warm_rst_active),
    .hot_rst_pulse(hot_rst_pulse), .irq_out(irq_out),
    .lock_first_block(lock_first_block));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    host.xfer(1'b1, idx, d, v);
  endtask
  task automatic rd(input logic [15:0] idx);
    host.xfer(1'b0, idx, 32'h0, v);
  endtask
  task automatic op(input logic [15:0] c);
    @(posedge hclk);
    op_evt <= {1'b1, c};
    @(posedge hclk);
    op_evt <= '0;
  endtask
  task automatic cmd();
    @(posedge hclk);
    cmd_written <= 1'b1;
    @(posedge hclk);
    cmd_written <= 1'b0;
  endtask
  // Code for a count of wrong bits; three or more reads as two
  function automatic logic [31:0] code(input int e);
    return (e > 1) ? 32'h2 : 32'(e);
  endfunction
  task automatic t_reset();
    rd(IDX_IRQ_STATUS);
    cmp(v, 32'h8080);
    rd(IDX_PROTECT);
    cmp(v, 32'h0002);
    rd(IDX_ECC);
    cmp(v, 32'h0000);
    rd(16'h0100);
    cmp(v, 32'h0000);
    cmp(hresp, 32'h0);
  endtask
  task automatic t_flags();
    logic [15:0] cm [9];
    cm = '{CMD_PROG_A, CMD_PROG_B, CMD_PROG_C, CMD_ERASE_A, CMD_ERASE_B,
      CMD_ERASE_C, CMD_RST_A, CMD_RST_B, CMD_RST_C};
    for (int i = 0; i < 9; i++) begin
      wr(IDX_IRQ_STATUS, 32'h0);
      @(negedge hclk);
      cmp(irq_out, 32'h0);
      op(cm[i]);
      rd(IDX_IRQ_STATUS);
      cmp(v, 32'h8000 | (32'h40 >> (i / 3)));
      cmp(irq_out, 32'h1);
    end
    // Commands outside the flag groups still raise the master bit
    wr(IDX_IRQ_STATUS, 32'h0);
    op(CMD_MISC_B);
    rd(IDX_IRQ_STATUS);
    cmp(v, 32'h8000);
  endtask
  task automatic t_resets();
    // Reset flag is set first so that a hot reset could wrongly clear it
    wr(IDX_IRQ_STATUS, 32'h0);
    op(CMD_RST_A);
    op(CMD_PROG_A);
    @(posedge hclk);
    hot_rst_pulse <= 1'b1;
    @(posedge hclk);
    hot_rst_pulse <= 1'b0;
    rd(IDX_IRQ_STATUS);
    cmp(v, 32'h8010);
    wr(IDX_IRQ_STATUS, 32'h0);
    op(CMD_ERASE_A);
    @(posedge hclk);
    warm_rst_active <= 1'b1;
    repeat (3) @(posedge hclk);
    warm_rst_active <= 1'b0;
    repeat (2) @(posedge hclk);
    rd(IDX_IRQ_STATUS);
    cmp(v, 32'h8010);
  endtask
  task automatic t_auto();
    wr(IDX_IRQ_CTRL, 32'h3);
    op(CMD_PROG_B);
    cmd();
    rd(IDX_IRQ_STATUS);
    cmp(v & 32'hF0, 32'h0);
    wr(IDX_IRQ_CTRL, 32'h0);
    wr(IDX_IRQ_STATUS, 32'h0);
    @(negedge hclk);
    cmp(irq_out, 32'h1);
    wr(IDX_IRQ_CTRL, 32'h1);
  endtask
  task automatic t_lock();
    logic [2:0] ex [4];
    ex = '{3'h4, 3'h2, 3'h1, 3'h1};
    wr(IDX_LOCK_START, 32'hFFFF_FC05);
    rd(IDX_LOCK_START);
    cmp(v, 32'h5);
    cmp(lock_first_block, 32'h5);
    wr(IDX_FLASH_BLOCK, 32'h5);
    for (int i = 0; i < 4; i++) begin
      @(posedge hclk);
      lock_evt <= {1'b1, 2'(i % 3)};
      @(posedge hclk);
      lock_evt <= '0;
      rd(IDX_PROTECT);
      cmp(v, ex[i]);
    end
    wr(IDX_PROTECT, 32'h4);
    wr(IDX_LOCK_END, 32'hFFFF);
    rd(IDX_PROTECT);
    cmp(v, 32'h1);
    rd(IDX_LOCK_END);
    cmp(v, 32'h0);
    wr(IDX_FLASH_BLOCK, 32'h6);
    rd(IDX_PROTECT);
    cmp(v, 32'h2);
    // An open first block still reads closed while it is one-time locked
    wr(IDX_LOCK_START, 32'h0);
    wr(IDX_FLASH_BLOCK, 32'h0);
    @(posedge hclk);
    lock_evt <= {1'b1, 2'h0};
    otp_first_locked <= 1'b1;
    @(posedge hclk);
    lock_evt <= '0;
    rd(IDX_PROTECT);
    cmp(v, 32'h2);
    otp_first_locked <= 1'b0;
    rd(IDX_PROTECT);
    cmp(v, 32'h4);
  endtask
  task automatic t_ecc();
    logic [31:0] ex;
    ex = 32'h0;
    cmd();
    for (int s = 0; s < 4; s++) begin
      @(posedge hclk);
      ecc_evt <= {1'b1, 2'(s), 2'(s), 2'(3 - s)};
      ex |= (code(s) << (4 * s + 2)) | (code(3 - s) << (4 * s));
      @(posedge hclk);
      ecc_evt <= '0;
    end
    rd(IDX_ECC);
    cmp(v, ex);
    cmd();
    rd(IDX_ECC);
    cmp(v, 32'h0);
    @(posedge hclk);
    ecc_evt <= {1'b1, 2'h3, 2'h1, 2'h2};
    boot_load_done <= 1'b1;
    @(posedge hclk);
    ecc_evt <= '0;
    boot_load_done <= 1'b0;
    rd(IDX_ECC);
    cmp(v, 32'h6000);
  endtask
  task automatic give_verdict();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_flags();
    t_resets();
    t_auto();
    t_lock();
    t_ecc();
    give_verdict();
  end
  // The tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge hclk);
    n_fail++;
    give_verdict();
  end
endmodule // test_flash_status_registers
